// file: pmrm_pkg.sv
package pmrm_pkg;
  // ==========================================================
  // Register map (byte offsets)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BKP0   = 8'h08;
  localparam logic [7:0] ADDR_BKP1   = 8'h0c;
  // CTRL fields
  localparam int CTL_SVD_EN   = 0;
  localparam int CTL_SVD_FALL = 1;
  localparam int CTL_SVD_RISE = 2;
  localparam int CTL_LP_STOP  = 3;
  localparam int CTL_CLK_EXT  = 4;
  localparam int CTL_CSS_IE   = 5;
  localparam int CTL_MODE_LO  = 8;  // 2-bit request field
  localparam int CTL_MODE_HI  = 9;
  localparam int CTL_SVD_CLR  = 16; // write one clears detector flag
  localparam int CTL_CSS_CLR  = 17; // write one clears clock fail flag
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // STATUS fields
  localparam int ST_SVD_FLAG  = 0;
  localparam int ST_CSS_FLAG  = 1;
  localparam int ST_SVD_OUT   = 2;
  localparam int ST_CLK_EXT   = 3;
  localparam int ST_BOOT_LO   = 4;
  localparam int ST_STATE_LO  = 8;
  localparam int ST_SBY_WOKE  = 12;
  // Timing
  localparam int CLK_MHZ        = 20;
  localparam int RESTART_NS     = 500; // clock tree restart hold
  localparam int RESTART_CYC    = (RESTART_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_HOLD_CYC = 4;
  localparam int EXT_LINES      = 16;
  // Boot sources
  typedef enum logic [1:0] {
    BOOT_USER = 2'b00, BOOT_SYS = 2'b01, BOOT_SRAM = 2'b10
  } pmrm_boot_t;
  // Mode requests
  localparam logic [1:0] REQ_RUN     = 2'b00;
  localparam logic [1:0] REQ_SLEEP   = 2'b01;
  localparam logic [1:0] REQ_STOP    = 2'b10;
  localparam logic [1:0] REQ_STANDBY = 2'b11;
  typedef enum logic [2:0] {
    ST_RESET   = 3'b000,
    ST_RUN     = 3'b001,
    ST_SLEEP   = 3'b010,
    ST_STOP    = 3'b011,
    ST_RESTART = 3'b100,
    ST_STANDBY = 3'b101
  } pmrm_state_t;

  // Decode a bus byte address to a register select
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    reg_sel = a[3:2];
  endfunction : reg_sel
endpackage : pmrm_pkg

// file: pmrm_wake_if.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Wake event bundle between top and wake collector
interface pmrm_wake_if;
  logic [15:0] line_evt;
  logic        svd_out;
  logic        alarm;
  logic        wakeup_pin_rise;
  logic        stop_wake;
  logic        sby_wake;
  modport col (input line_evt, svd_out, alarm, wakeup_pin_rise, output stop_wake, sby_wake);
  modport top (output line_evt, svd_out, alarm, wakeup_pin_rise, input stop_wake, sby_wake);
endinterface : pmrm_wake_if
`default_nettype wire

// file: pmrm_wake.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Wake source collector
module pmrm_wake
  import pmrm_pkg::*;
(
  pmrm_wake_if.col w
);
  // Any external line event leaves Stop
  assign w.stop_wake = (|w.line_evt) | w.svd_out | w.alarm;
  // Wakeup pin edge or alarm leaves Standby
  assign w.sby_wake  = w.wakeup_pin_rise | w.alarm;
endmodule : pmrm_wake
`default_nettype wire

// file: pmrm_top.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Power, reset and mode manager
module pmrm_top
  import pmrm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Supply and pins
  input  wire logic        supply_low,
  input  wire logic        svd_below,
  input  wire logic [1:0]  boot_pins,
  input  wire logic        external_reset_pin,
  input  wire logic        independent_watchdog_rst,
  input  wire logic        wakeup_pin,
  input  wire logic        alarm_evt,
  input  wire logic [15:0] line_evt,
  input  wire logic        periph_evt,
  input  wire logic        ext_clk_fail,
  // Power and clock control
  output logic             core_reset,
  output logic             cpu_halt,
  output logic             core_clk_gate,
  output logic             pll_en,
  output logic             internal_fast_rc_osc_en,
  output logic             external_fast_osc_en,
  output logic             clk_sel_ext,
  output logic             regulator_main_mode,
  output logic             regulator_low_power_mode,
  output logic             regulator_hiz,
  output logic             always_on_en,
  output logic [1:0]       boot_sel,
  output logic             svd_irq,
  output logic             css_irq
);
  // ==========================================================
  // Registers
  pmrm_state_t state_ff, nxt_state;
  logic [31:0] ctrl_ff;
  logic [15:0] bkp0_ff, bkp1_ff;
  logic        svd_flag_ff, css_flag_ff, svd_prev_ff, wakeup_pin_prev_ff;
  logic        sby_woke_ff, clk_ext_ff;
  logic [1:0]  boot_ff;
  logic [7:0]  cnt_ff;
  logic        wr_pend_ff, rd_pend_ff;
  logic [7:0]  addr_ff;
  logic        rst_req;
  pmrm_wake_if wif ();

  assign wif.line_evt  = line_evt;
  assign wif.svd_out   = svd_below;
  assign wif.alarm     = alarm_evt;
  assign wif.wakeup_pin_rise = wakeup_pin & ~wakeup_pin_prev_ff;

  pmrm_wake u_wake (
    .w (wif.col)
  );

  // Reset sources: supply, pin, watchdog
  assign rst_req = srst | supply_low | external_reset_pin | independent_watchdog_rst;

  // ==========================================================
  // AHB-Lite slave, zero wait, always OKAY
  logic acc;
  assign acc       = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end else begin
      wr_pend_ff <= acc & hwrite;
      rd_pend_ff <= acc & ~hwrite;
      if (acc) addr_ff <= haddr;
    end
  end

  // Control register, lost in Standby
  always_ff @(posedge clk) begin
    if (rst_req || state_ff == ST_STANDBY) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_pend_ff && reg_sel(addr_ff) == reg_sel(ADDR_CTRL)) begin
      ctrl_ff <= hwdata & 32'h0000_033f;
    end else if (state_ff == ST_RUN && ctrl_ff[CTL_MODE_HI:CTL_MODE_LO] != REQ_RUN) begin
      ctrl_ff[CTL_MODE_HI:CTL_MODE_LO] <= REQ_RUN; // request consumed
    end
  end

  // Backup words: no reset of any kind touches them
  always_ff @(posedge clk) begin
    if (wr_pend_ff && reg_sel(addr_ff) == reg_sel(ADDR_BKP0)) bkp0_ff <= hwdata[15:0];
    if (wr_pend_ff && reg_sel(addr_ff) == reg_sel(ADDR_BKP1)) bkp1_ff <= hwdata[15:0];
  end

  // Read data
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      unique case (reg_sel(haddr))
        2'd0: hrdata <= ctrl_ff;
        2'd1: begin
          hrdata <= 32'h0000_0000;
          hrdata[ST_SVD_FLAG]               <= svd_flag_ff;
          hrdata[ST_CSS_FLAG]               <= css_flag_ff;
          hrdata[ST_SVD_OUT]                <= svd_below;
          hrdata[ST_CLK_EXT]                <= clk_ext_ff;
          hrdata[ST_BOOT_LO+1:ST_BOOT_LO]   <= boot_ff;
          hrdata[ST_STATE_LO+2:ST_STATE_LO] <= state_ff;
          hrdata[ST_SBY_WOKE]               <= sby_woke_ff;
        end
        2'd2: hrdata <= {16'h0000, bkp0_ff};
        2'd3: hrdata <= {16'h0000, bkp1_ff};
      endcase
    end
  end

  // ==========================================================
  // Supply detector: edge flags, set wins over clear
  logic svd_fall, svd_rise, svd_clr;
  assign svd_fall = svd_below & ~svd_prev_ff;
  assign svd_rise = ~svd_below & svd_prev_ff;
  assign svd_clr  = wr_pend_ff && reg_sel(addr_ff) == reg_sel(ADDR_CTRL) && hwdata[CTL_SVD_CLR];
  always_ff @(posedge clk) begin
    if (rst_req) begin
      svd_prev_ff <= 1'b0;
      svd_flag_ff <= 1'b0;
    end else begin
      svd_prev_ff <= svd_below;
      if (ctrl_ff[CTL_SVD_EN] && ((svd_fall && ctrl_ff[CTL_SVD_FALL]) ||
                                  (svd_rise && ctrl_ff[CTL_SVD_RISE])))
        svd_flag_ff <= 1'b1;
      else if (svd_clr)
        svd_flag_ff <= 1'b0;
    end
  end
  assign svd_irq = svd_flag_ff & ctrl_ff[CTL_SVD_EN];

  // ==========================================================
  // Clock select and failure fallback
  logic css_clr;
  assign css_clr = wr_pend_ff && reg_sel(addr_ff) == reg_sel(ADDR_CTRL) && hwdata[CTL_CSS_CLR];
  always_ff @(posedge clk) begin
    if (rst_req || state_ff != ST_RUN) begin
      clk_ext_ff <= 1'b0;
    end else if (clk_ext_ff && ext_clk_fail) begin
      clk_ext_ff <= 1'b0;
    end else begin
      clk_ext_ff <= ctrl_ff[CTL_CLK_EXT] & ~ext_clk_fail;
    end
  end
  always_ff @(posedge clk) begin
    if (rst_req) css_flag_ff <= 1'b0;
    else if (clk_ext_ff && ext_clk_fail) css_flag_ff <= 1'b1;
    else if (css_clr) css_flag_ff <= 1'b0;
  end
  assign css_irq     = css_flag_ff & ctrl_ff[CTL_CSS_IE];
  assign clk_sel_ext = clk_ext_ff;

  // Boot pins caught at the end of reset
  always_ff @(posedge clk) begin
    if (state_ff == ST_RESET && nxt_state == ST_RUN)
      boot_ff <= (boot_pins == 2'b11) ? BOOT_USER : boot_pins;
  end
  assign boot_sel = boot_ff;

  // Standby wake marker survives the restart
  always_ff @(posedge clk) begin
    if (srst) sby_woke_ff <= 1'b0;
    else if (state_ff == ST_STANDBY && (wif.sby_wake || rst_req)) sby_woke_ff <= 1'b1;
    else if (css_clr) sby_woke_ff <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (srst) wakeup_pin_prev_ff <= 1'b0;
    else      wakeup_pin_prev_ff <= wakeup_pin;
  end

  // ==========================================================
  // Mode sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RESET:   if (cnt_ff == 8'(RESET_HOLD_CYC)) nxt_state = ST_RUN;
      ST_RUN: begin
        unique case (ctrl_ff[CTL_MODE_HI:CTL_MODE_LO])
          REQ_SLEEP:   nxt_state = ST_SLEEP;
          REQ_STOP:    nxt_state = ST_STOP;
          REQ_STANDBY: nxt_state = ST_STANDBY;
          default:     nxt_state = ST_RUN;
        endcase
      end
      ST_SLEEP:   if (periph_evt || wif.stop_wake) nxt_state = ST_RUN;
      ST_STOP:    if (wif.stop_wake) nxt_state = ST_RESTART;
      ST_RESTART: if (cnt_ff == 8'(RESTART_CYC)) nxt_state = ST_RUN;
      ST_STANDBY: if (wif.sby_wake) nxt_state = ST_RESET;
      default:    nxt_state = ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst_req) state_ff <= ST_RESET;
    else         state_ff <= nxt_state;
  end

  // Hold and restart counter
  always_ff @(posedge clk) begin
    if (rst_req || state_ff != nxt_state) cnt_ff <= 8'h00;
    else if (cnt_ff != 8'hff)             cnt_ff <= cnt_ff + 8'h01;
  end

  // ==========================================================
  // Power and clock outputs
  assign core_reset    = (state_ff == ST_RESET);
  assign cpu_halt      = (state_ff != ST_RUN);
  assign core_clk_gate = (state_ff == ST_STOP) | (state_ff == ST_STANDBY);
  assign pll_en        = ~core_clk_gate & (state_ff != ST_RESTART);
  assign internal_fast_rc_osc_en = ~core_clk_gate;
  assign external_fast_osc_en    = ~core_clk_gate & ctrl_ff[CTL_CLK_EXT] & (state_ff == ST_RUN);
  assign regulator_hiz = (state_ff == ST_STANDBY);
  assign regulator_low_power_mode = (state_ff == ST_STOP) & ctrl_ff[CTL_LP_STOP];
  assign regulator_main_mode = ~regulator_hiz & ~regulator_low_power_mode;
  assign always_on_en  = 1'b1;

  // ==========================================================
  // Checks
  // Pending mode request, watched by the regulator check
  logic [1:0] mode_req;
  assign mode_req = ctrl_ff[CTL_MODE_HI:CTL_MODE_LO];
  property p_reg_off;
    @(posedge clk) disable iff (srst)
      $rose(regulator_hiz) |-> $past(state_ff) == ST_RUN && $past(mode_req) == REQ_STANDBY;
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("regulator off without request");
  property p_rst_regon;
    @(posedge clk) disable iff (srst) core_reset |-> regulator_main_mode && !regulator_hiz;
  endproperty
  a_rst_regon: assert property (p_rst_regon) else $error("regulator not on in reset");
  property p_clk_rst;
    @(posedge clk) disable iff (srst) core_reset |-> !clk_sel_ext && internal_fast_rc_osc_en;
  endproperty
  a_clk_rst: assert property (p_clk_rst) else $error("reset not on rc clock");
  property p_rst_hold;
    @(posedge clk) disable iff (srst) supply_low |=> core_reset;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset not held");
  property p_stop_wake;
    @(posedge clk) disable iff (srst)
      (state_ff == ST_STOP && |line_evt && !rst_req) |=> state_ff == ST_RESTART;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop not left");
  property p_sby_wake;
    @(posedge clk) disable iff (srst)
      (state_ff == ST_STANDBY && alarm_evt) |=> core_reset;
  endproperty
  a_sby_wake: assert property (p_sby_wake) else $error("standby not left");
  property p_css;
    @(posedge clk) disable iff (srst)
      (clk_sel_ext && ext_clk_fail && !rst_req) |=> !clk_sel_ext && css_flag_ff;
  endproperty
  a_css: assert property (p_css) else $error("no clock fallback");
  property p_stop_clk;
    @(posedge clk) disable iff (srst) state_ff == ST_STOP |-> !pll_en && !external_fast_osc_en;
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("clocks on in stop");
  property p_restart;
    @(posedge clk) disable iff (srst) state_ff == ST_RESTART |-> !clk_sel_ext && !pll_en;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not on rc");
  property p_sleep;
    @(posedge clk) disable iff (srst)
      (state_ff == ST_SLEEP && periph_evt && !rst_req) |=> state_ff == ST_RUN;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not left");
  property p_stop_keep;
    @(posedge clk) disable iff (srst)
      (state_ff == ST_STOP && !wif.stop_wake && !rst_req) |=> state_ff == ST_STOP;
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("stop left without event");
  property p_boot;
    @(posedge clk) disable iff (srst)
      $fell(core_reset) |-> boot_sel == (($past(boot_pins) == 2'b11) ? 2'b00 : $past(boot_pins));
  endproperty
  a_boot: assert property (p_boot) else $error("boot source not taken");
  property p_svd_set;
    @(posedge clk) disable iff (srst)
      (ctrl_ff[CTL_SVD_EN] && ctrl_ff[CTL_SVD_FALL] && svd_fall && !rst_req) |=> svd_flag_ff;
  endproperty
  a_svd_set: assert property (p_svd_set) else $error("detector flag not set");
endmodule : pmrm_top
`default_nettype wire

// file: pmrm_wake_src.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Wake source model: raises the source chosen by src
module pmrm_wake_src (
  input  wire logic [3:0]  src,
  output logic      [15:0] line_evt,
  output logic             svd_below,
  output logic             alarm_evt,
  output logic             wakeup_pin,
  output logic             external_reset_pin,
  output logic             independent_watchdog_rst,
  output logic             periph_evt
);
  // Decode of the requested source, all quiet at zero
  always_comb begin
    line_evt                 = 16'h0000;
    svd_below                = (src == 4'h3);
    alarm_evt                = (src == 4'h4);
    wakeup_pin               = (src == 4'h5);
    external_reset_pin       = (src == 4'h6);
    independent_watchdog_rst = (src == 4'h7);
    periph_evt               = (src == 4'h8);
    line_evt[0]              = (src == 4'h1);
    line_evt[15]             = (src == 4'h2);
  end
endmodule : pmrm_wake_src
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Testbench for the power and mode manager
module tb
  import pmrm_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        supply_low = 1'b0;
  logic        ext_clk_fail = 1'b0;
  logic [1:0]  boot_pins = 2'b01;
  logic [3:0]  src = 4'h0;
  logic [31:0] hrdata, q;
  logic [15:0] line_evt;
  logic [1:0]  boot_sel;
  logic        hreadyout, hresp, svd_below, alarm_evt, wakeup_pin, external_reset_pin;
  logic        independent_watchdog_rst, periph_evt, core_reset, cpu_halt, core_clk_gate;
  logic        pll_en, internal_fast_rc_osc_en, external_fast_osc_en, clk_sel_ext;
  logic        regulator_main_mode, regulator_low_power_mode, regulator_hiz;
  logic        always_on_en, svd_irq, css_irq;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          waited;

  // ==========================================================
  // Design and wake source model
  pmrm_top pmrm_top_i (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .supply_low, .svd_below,
    .boot_pins, .external_reset_pin, .independent_watchdog_rst, .wakeup_pin, .alarm_evt,
    .line_evt, .periph_evt, .ext_clk_fail, .core_reset, .cpu_halt, .core_clk_gate, .pll_en,
    .internal_fast_rc_osc_en, .external_fast_osc_en, .clk_sel_ext, .regulator_main_mode,
    .regulator_low_power_mode, .regulator_hiz, .always_on_en, .boot_sel, .svd_irq,
    .css_irq);
  pmrm_wake_src pmrm_wake_src_i (.src, .line_evt, .svd_below, .alarm_evt, .wakeup_pin,
    .external_reset_pin, .independent_watchdog_rst, .periph_evt);

  always #25 clk = ~clk;

  // ==========================================================
  // Shared tasks
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait for a watched output to reach v, sampled at falling edges
  task automatic wait_sig(input int s, input logic v);
    logic x;
    for (waited = 0; waited < 300; waited++) begin
      @(negedge clk);
      case (s)
        0: x = cpu_halt;
        1: x = core_reset;
        2: x = clk_sel_ext;
        3: x = css_irq;
        default: x = svd_irq;
      endcase
      if (x === v) break;
    end
    if (waited == 300) begin
      miscompares++;
      finish_test();
    end
  endtask : wait_sig

  // Single AHB transfer, hready polled at each phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    for (int n = 0; n < 2; n++) begin
      for (waited = 0; waited < 50; waited++) begin
        @(posedge clk);
        if (hreadyout === 1'b1) break;
      end
      if (waited == 50) begin
        miscompares++;
        finish_test();
      end
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
    end
    q = hrdata;
  endtask : bus

  // Holds a wake source for two cycles
  task automatic pulse(input logic [3:0] c);
    @(posedge clk);
    src <= c;
    repeat (2) @(posedge clk);
    src <= 4'h0;
  endtask : pulse

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    repeat (19) @(posedge clk);
    @(negedge clk);
    chk({core_reset, regulator_main_mode, clk_sel_ext}, 3'b110);
    chk({internal_fast_rc_osc_en, svd_irq, css_irq}, 3'b100);
    @(posedge clk);
    srst <= 1'b0;
    wait_sig(0, 1'b0);
    chk({core_reset, regulator_hiz, boot_sel, hresp}, 5'b00010);
  endtask : t_reset

  task automatic t_sleep;
    bus(1'b1, ADDR_CTRL, 32'h0000_0100);
    wait_sig(0, 1'b1);
    chk({core_clk_gate, internal_fast_rc_osc_en, core_reset}, 3'b010);
    bus(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(q[10:8], 3'd2);
    pulse(4'h8);
    wait_sig(0, 1'b0);
  endtask : t_sleep

  task automatic t_stop(input logic [3:0] c, input logic lp);
    bus(1'b1, ADDR_BKP1, {16'h0000, 12'ha5c, c});
    bus(1'b1, ADDR_CTRL, lp ? 32'h0000_020b : 32'h0000_0203);
    wait_sig(0, 1'b1);
    chk({core_clk_gate, pll_en, internal_fast_rc_osc_en, external_fast_osc_en}, 4'h8);
    chk({regulator_low_power_mode, regulator_main_mode, core_reset}, {lp, !lp, 1'b0});
    chk(always_on_en, 1'b1);
    pulse(c);
    wait_sig(0, 1'b0);
    chk(waited, RESTART_CYC);
    chk({internal_fast_rc_osc_en, clk_sel_ext}, 2'b10);
    bus(1'b0, ADDR_BKP1, 32'h0000_0000);
    chk(q[15:0], {12'ha5c, c});
    bus(1'b1, ADDR_CTRL, 32'h0001_0000);
  endtask : t_stop

  task automatic t_standby(input logic [3:0] c, input logic [1:0] b);
    bus(1'b1, ADDR_BKP0, {16'h0000, 12'h5a3, c});
    boot_pins <= b;
    bus(1'b1, ADDR_CTRL, 32'h0000_0300);
    wait_sig(0, 1'b1);
    chk({regulator_hiz, regulator_main_mode, regulator_low_power_mode}, 3'b100);
    chk({core_clk_gate, pll_en, internal_fast_rc_osc_en, external_fast_osc_en}, 4'h8);
    chk(always_on_en, 1'b1);
    pulse(c);
    wait_sig(1, 1'b1);
    wait_sig(0, 1'b0);
    chk({regulator_main_mode, regulator_hiz, clk_sel_ext}, 3'b100);
    chk(boot_sel, (b == 2'b11) ? 2'b00 : b);
    bus(1'b0, ADDR_BKP0, 32'h0000_0000);
    chk(q[15:0], {12'h5a3, c});
    bus(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk({q[12], q[10:8]}, {1'b1, ST_RUN});
    bus(1'b1, ADDR_CTRL, 32'h0002_0000);
  endtask : t_standby

  task automatic t_supply;
    @(posedge clk);
    supply_low <= 1'b1;
    @(posedge clk);
    repeat (30) begin
      @(negedge clk);
      chk(core_reset, 1'b1);
    end
    @(posedge clk);
    supply_low <= 1'b0;
    wait_sig(0, 1'b0);
    bus(1'b0, ADDR_BKP0, 32'h0000_0000);
    chk(q[15:0], 16'h5a37);
  endtask : t_supply

  task automatic t_svd_css;
    bus(1'b1, ADDR_CTRL, 32'h0000_0003);
    pulse(4'h3);
    wait_sig(4, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h0001_0001);
    wait_sig(4, 1'b0);
    pulse(4'h3);
    repeat (5) @(negedge clk);
    chk(svd_irq, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h0000_0005);
    pulse(4'h3);
    wait_sig(4, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h0001_0000);
    bus(1'b1, ADDR_CTRL, 32'h0000_0030);
    wait_sig(2, 1'b1);
    chk(external_fast_osc_en, 1'b1);
    @(posedge clk);
    ext_clk_fail <= 1'b1;
    wait_sig(2, 1'b0);
    wait_sig(3, 1'b1);
    chk(internal_fast_rc_osc_en, 1'b1);
    @(posedge clk);
    ext_clk_fail <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h0002_0000);
    wait_sig(3, 1'b0);
  endtask : t_svd_css

  // ==========================================================
  // Main sequence
  initial begin
    t_reset();
    t_sleep();
    t_stop(4'h1, 1'b1);
    t_stop(4'h2, 1'b0);
    t_stop(4'h3, 1'b1);
    t_stop(4'h4, 1'b0);
    for (int i = 0; i < 4; i++) begin
      t_standby(4'(i + 4), 2'(i));
    end
    t_supply();
    t_svd_css();
    finish_test();
  end
endmodule : tb
`default_nettype wire
